// ===== hw/iod_core.sv
// Indexed operand decoder core: takes one instruction word per instruction
// cycle, runs it over four quarter phases and drives the data memory port.
// Assumes a data memory that returns read data one clock after MEM_RD.
`timescale 1ns/10ps
`include "iod_params.svh"

module iod_core (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic [15:0] INSTR_WORD,
  input  wire logic        INSTR_VALID,
  input  wire logic [2:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic      [11:0] MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             MEM_WR,
  output logic      [7:0]  MEM_WDATA,
  output logic             PHASE_Q1,
  output logic             EXEC_DONE
);

  iod_exec_if xif ();

  iod_exec u_exec (
    .xif (xif.exec)
  );

  // ========================================================================
  // State
  iod_pkg::iod_phase_type phase_reg,  phase_next;
  iod_pkg::iod_kind_type  kind_reg,   kind_next;
  iod_pkg::iod_flags_type flags_reg,  flags_next;
  logic [15:0]            instr_reg,  instr_next;
  logic                   active_reg, active_next;
  logic [11:0]            addr_reg,   addr_next;
  logic                   rd_reg,     rd_next;
  logic                   wr_reg,     wr_next;
  logic [7:0]             wdata_reg,  wdata_next;
  logic                   done_reg,   done_next;
  logic                   q1_reg,     q1_next;
  logic                   ext_reg,    ext_next;
  logic [11:0]            fp_reg,     fp_next;
  logic [3:0]             bsr_reg,    bsr_next;
  logic [7:0]             work_reg,   work_next;
  logic [7:0]             rdata_reg,  rdata_next;
  logic                   take_now;
  logic                   exec_q3;

  assign REG_RDATA = rdata_reg;
  assign MEM_ADDR  = addr_reg;
  assign MEM_RD    = rd_reg;
  assign MEM_WR    = wr_reg;
  assign MEM_WDATA = wdata_reg;
  assign PHASE_Q1  = q1_reg;
  assign EXEC_DONE = done_reg;

  // The unit sees the incoming word during Q1 so the address is ready by Q2
  assign xif.instr   = (phase_reg == iod_pkg::IOD_Q1) ? INSTR_WORD : instr_reg;
  assign xif.ext_en  = ext_reg;
  assign xif.fp      = fp_reg;
  assign xif.bank_select_reg     = bsr_reg;
  assign xif.work    = work_reg;
  assign xif.operand = MEM_RDATA;

  assign take_now = (phase_reg == iod_pkg::IOD_Q1) && INSTR_VALID
                    && (xif.kind != iod_pkg::IOD_K_NONE);
  assign exec_q3  = (phase_reg == iod_pkg::IOD_Q3) && active_reg;

  // ========================================================================
  // Instruction sequencer: decode, read, process, write
  always_comb begin
    phase_next  = phase_reg;
    kind_next   = kind_reg;
    instr_next  = instr_reg;
    active_next = active_reg;
    addr_next   = addr_reg;
    rd_next     = 1'b0;
    wr_next     = 1'b0;
    wdata_next  = wdata_reg;
    done_next   = 1'b0;
    case (phase_reg)
      iod_pkg::IOD_Q1: begin
        phase_next  = iod_pkg::IOD_Q2;
        active_next = take_now;
        if (take_now) begin
          instr_next = INSTR_WORD;
          kind_next  = xif.kind;
          addr_next  = xif.eff_addr;
          // Fill needs no operand, so no read is issued for it
          rd_next    = (xif.kind != iod_pkg::IOD_K_FILL);
        end
      end
      iod_pkg::IOD_Q2: begin
        phase_next = iod_pkg::IOD_Q3;
      end
      iod_pkg::IOD_Q3: begin
        phase_next = iod_pkg::IOD_Q4;
        if (active_reg) begin
          wdata_next = xif.result;
          wr_next    = !xif.dest_w;
          done_next  = 1'b1;
        end
      end
      iod_pkg::IOD_Q4: begin
        phase_next  = iod_pkg::IOD_Q1;
        active_next = 1'b0;
      end
      default: begin
        phase_next  = iod_pkg::IOD_Q1;
        active_next = 1'b0;
      end
    endcase
    q1_next = (phase_next == iod_pkg::IOD_Q1);
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      phase_reg  <= iod_pkg::IOD_Q1;
      kind_reg   <= iod_pkg::IOD_K_NONE;
      instr_reg  <= 16'h0000;
      active_reg <= 1'b0;
      addr_reg   <= 12'h000;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      wdata_reg  <= 8'h00;
      done_reg   <= 1'b0;
      q1_reg     <= 1'b1;
    end else begin
      phase_reg  <= phase_next;
      kind_reg   <= kind_next;
      instr_reg  <= instr_next;
      active_reg <= active_next;
      addr_reg   <= addr_next;
      rd_reg     <= rd_next;
      wr_reg     <= wr_next;
      wdata_reg  <= wdata_next;
      done_reg   <= done_next;
      q1_reg     <= q1_next;
    end
  end

  // ========================================================================
  // Register file: configuration, frame pointer, bank, work, status
  always_comb begin
    ext_next   = ext_reg;
    fp_next    = fp_reg;
    bsr_next   = bsr_reg;
    work_next  = work_reg;
    flags_next = flags_reg;
    rdata_next = 8'h00;
    if (REG_WR) begin
      case (REG_ADDR)
        `IOD_REG_CFG:   ext_next = REG_WDATA[`IOD_CFG_EXT_BIT];
        `IOD_REG_FP_LO: fp_next  = {fp_reg[11:8], REG_WDATA};
        `IOD_REG_FP_HI: fp_next  = {REG_WDATA[3:0], fp_reg[7:0]};
        `IOD_REG_BANK:  bsr_next = REG_WDATA[3:0];
        `IOD_REG_WORK:  work_next = REG_WDATA;
        default:        ext_next = ext_reg;
      endcase
    end
    // Execution lands after the software write, so it wins a collision
    if (exec_q3 && (kind_reg == iod_pkg::IOD_K_ADD)) begin
      flags_next = xif.flags;
      if (xif.dest_w) begin
        work_next = xif.result;
      end
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `IOD_REG_CFG:    rdata_next = {7'h00, ext_reg};
        `IOD_REG_FP_LO:  rdata_next = fp_reg[7:0];
        `IOD_REG_FP_HI:  rdata_next = {4'h0, fp_reg[11:8]};
        `IOD_REG_BANK:   rdata_next = {4'h0, bsr_reg};
        `IOD_REG_WORK:   rdata_next = work_reg;
        `IOD_REG_STATUS: rdata_next = {3'h0, flags_reg};
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ext_reg   <= `IOD_CFG_RESET;
      fp_reg    <= `IOD_FP_RESET;
      bsr_reg   <= `IOD_BANK_RESET;
      work_reg  <= `IOD_WORK_RESET;
      flags_reg <= 5'h00;
      rdata_reg <= 8'h00;
    end else begin
      ext_reg   <= ext_next;
      fp_reg    <= fp_next;
      bsr_reg   <= bsr_next;
      work_reg  <= work_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
    end
  end

  // ========================================================================
  // Assertions
  logic [8:0] sum_chk;
  assign sum_chk = {1'b0, work_reg} + {1'b0, MEM_RDATA};

  AST_INDEXED_ADDR: assert property (@(posedge REF_CLK) disable iff (RESET)
    (take_now && ext_reg && !INSTR_WORD[8] && (INSTR_WORD[7:0] <= `IOD_OFFSET_LIMIT))
    |=> (MEM_ADDR == 12'($past(fp_reg) + {4'h0, $past(INSTR_WORD[7:0])})))
    else $error("indexed operand address is wrong");

  AST_ADD_TO_BYTE: assert property (@(posedge REF_CLK) disable iff (RESET)
    (exec_q3 && (kind_reg == iod_pkg::IOD_K_ADD) && instr_reg[9])
    |=> (MEM_WR && (MEM_WDATA == $past(sum_chk[7:0])) && $stable(work_reg)))
    else $error("indexed add did not write the byte");

  AST_ADD_TO_WORK: assert property (@(posedge REF_CLK) disable iff (RESET)
    (exec_q3 && (kind_reg == iod_pkg::IOD_K_ADD) && !instr_reg[9])
    |=> (!MEM_WR && (work_reg == $past(sum_chk[7:0]))))
    else $error("indexed add did not load the work register");

  AST_ADD_FLAGS: assert property (@(posedge REF_CLK) disable iff (RESET)
    (exec_q3 && (kind_reg == iod_pkg::IOD_K_ADD))
    |=> ((flags_reg.cy == $past(sum_chk[8]))
         && (flags_reg.zero == ($past(sum_chk[7:0]) == 8'h00))
         && (flags_reg.neg == $past(sum_chk[7]))
         && (flags_reg.ovf == (($past(work_reg[7]) == $past(MEM_RDATA[7]))
                               && ($past(sum_chk[7]) != $past(work_reg[7]))))
         && (flags_reg.dcy == (({1'b0, $past(work_reg[3:0])}
                                + {1'b0, $past(MEM_RDATA[3:0])}) > 5'h0F))))
    else $error("indexed add flags are wrong");

  AST_BIT_SET: assert property (@(posedge REF_CLK) disable iff (RESET)
    (exec_q3 && (kind_reg == iod_pkg::IOD_K_BSET))
    |=> (MEM_WR && (MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << $past(instr_reg[11:9]))))
         && $stable(flags_reg)))
    else $error("bit set result or flags wrong");

  AST_FILL: assert property (@(posedge REF_CLK) disable iff (RESET)
    (take_now && (xif.kind == iod_pkg::IOD_K_FILL))
    |=> !MEM_RD ##2 (MEM_WR && (MEM_WDATA == `IOD_FILL_VALUE) && $stable(flags_reg)))
    else $error("fill did not write all ones");

  AST_ONE_CYCLE: assert property (@(posedge REF_CLK) disable iff (RESET)
    take_now |=> !EXEC_DONE ##1 !EXEC_DONE ##1 EXEC_DONE ##1 (PHASE_Q1 && !EXEC_DONE))
    else $error("instruction did not finish in one instruction cycle");

  AST_DISABLED_LITERAL: assert property (@(posedge REF_CLK) disable iff (RESET)
    (take_now && !ext_reg && !INSTR_WORD[8])
    |=> ((MEM_ADDR[7:0] == $past(INSTR_WORD[7:0]))
         && (MEM_ADDR[11:8] == (($past(INSTR_WORD[7:0]) <= `IOD_OFFSET_LIMIT)
                                ? `IOD_LOW_PAGE : `IOD_HIGH_PAGE))))
    else $error("literal access address wrong with extension off");

  AST_BANKED: assert property (@(posedge REF_CLK) disable iff (RESET)
    (take_now && INSTR_WORD[8])
    |=> (MEM_ADDR == {$past(bsr_reg), $past(INSTR_WORD[7:0])}))
    else $error("banked address wrong");

  AST_HIGH_ACCESS: assert property (@(posedge REF_CLK) disable iff (RESET)
    (take_now && !INSTR_WORD[8] && (INSTR_WORD[7:0] > `IOD_OFFSET_LIMIT))
    |=> (MEM_ADDR == {`IOD_HIGH_PAGE, $past(INSTR_WORD[7:0])}))
    else $error("high access operand was indexed");

endmodule // iod_core

// ===== hw/iod_exec.sv
// Combinational decode, operand address and data path of one instruction.
// Assumes the core holds the instruction word and register state stable.
`timescale 1ns/10ps
`include "iod_params.svh"

module iod_exec (
  iod_exec_if.exec xif
);

  // Unextended access bank: low part from page 0, high part from the top page
  function automatic logic [11:0] iod_access_map(input logic [7:0] f);
    iod_access_map = (f <= `IOD_OFFSET_LIMIT) ? {`IOD_LOW_PAGE, f} : {`IOD_HIGH_PAGE, f};
  endfunction

  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [7:0] fld;

  // ========================================================================
  // Decode and address
  always_comb begin
    fld      = xif.instr[7:0];
    xif.kind = iod_pkg::IOD_K_NONE;
    if (xif.instr[15:10] == `IOD_OP_ADD) begin
      xif.kind = iod_pkg::IOD_K_ADD;
    end else if (xif.instr[15:12] == `IOD_OP_BSET) begin
      xif.kind = iod_pkg::IOD_K_BSET;
    end else if (xif.instr[15:9] == `IOD_OP_FILL) begin
      xif.kind = iod_pkg::IOD_K_FILL;
    end
    if (xif.instr[8]) begin
      xif.eff_addr = {xif.bank_select_reg, fld};
    end else if (xif.ext_en && (fld <= `IOD_OFFSET_LIMIT)) begin
      // A zero frame pointer lands on the unextended address
      xif.eff_addr = xif.fp + {4'h0, fld};
    end else begin
      xif.eff_addr = iod_access_map(fld);
    end
  end

  // ========================================================================
  // Data path
  always_comb begin
    sum9       = {1'b0, xif.work} + {1'b0, xif.operand};
    sum_lo     = {1'b0, xif.work[3:0]} + {1'b0, xif.operand[3:0]};
    xif.flags.cy   = sum9[8];
    xif.flags.dcy  = sum_lo[4];
    xif.flags.zero = (sum9[7:0] == 8'h00);
    xif.flags.neg  = sum9[7];
    xif.flags.ovf  = (xif.work[7] == xif.operand[7]) && (sum9[7] != xif.work[7]);
    xif.dest_w     = (xif.kind == iod_pkg::IOD_K_ADD) && !xif.instr[9];
    case (xif.kind)
      iod_pkg::IOD_K_ADD: begin
        xif.result = sum9[7:0];
      end
      iod_pkg::IOD_K_BSET: begin
        xif.result = xif.operand | (8'h01 << xif.instr[11:9]);
      end
      iod_pkg::IOD_K_FILL: begin
        xif.result = `IOD_FILL_VALUE;
      end
      default: begin
        xif.result = xif.operand;
      end
    endcase
  end

endmodule // iod_exec

// ===== shared/iod_exec_if.sv
// Carrier between the decoder core and its execution unit.
// Assumes both ends run in the same clock domain; the unit is combinational.
`timescale 1ns/10ps

interface iod_exec_if;
  logic [15:0]            instr;
  logic                   ext_en;
  logic [11:0]            fp;
  logic [3:0]             bank_select_reg;
  logic [7:0]             work;
  logic [7:0]             operand;
  iod_pkg::iod_kind_type  kind;
  logic [11:0]            eff_addr;
  logic [7:0]             result;
  iod_pkg::iod_flags_type flags;
  logic                   dest_w;

  modport core (output instr, ext_en, fp, bank_select_reg, work, operand,
                input  kind, eff_addr, result, flags, dest_w);
  modport exec (input  instr, ext_en, fp, bank_select_reg, work, operand,
                output kind, eff_addr, result, flags, dest_w);
endinterface

// ===== shared/iod_params.svh
// Constants of the indexed operand decoder: register offsets, field positions,
// reset values and opcode patterns. Included by the design files by bare name.
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH

// ==========================================================================
// Operand mapping
`define IOD_OFFSET_LIMIT   8'h5F
`define IOD_HIGH_PAGE      4'hF
`define IOD_LOW_PAGE       4'h0
`define IOD_FILL_VALUE     8'hFF

// ==========================================================================
// Register offsets on the plain register port
`define IOD_REG_CFG        3'h0
`define IOD_REG_FP_LO      3'h1
`define IOD_REG_FP_HI      3'h2
`define IOD_REG_BANK       3'h3
`define IOD_REG_WORK       3'h4
`define IOD_REG_STATUS     3'h5

// ==========================================================================
// Field positions and reset values
`define IOD_CFG_EXT_BIT    0
`define IOD_CFG_RESET      1'b0
`define IOD_FP_RESET       12'h000
`define IOD_BANK_RESET     4'h0
`define IOD_WORK_RESET     8'h00

// ==========================================================================
// Opcode patterns (upper bits of the instruction word)
`define IOD_OP_ADD         6'h09
`define IOD_OP_BSET        4'h8
`define IOD_OP_FILL        7'h34

`endif

// ===== shared/iod_pkg.sv
// Types shared by the indexed operand decoder and its execution unit.
// Assumes nothing of its surroundings.
package iod_pkg;

  // ========================================================================
  // Quarter phases of one instruction cycle, Gray coded
  typedef enum logic [1:0] {
    IOD_Q1 = 2'h0,
    IOD_Q2 = 2'h1,
    IOD_Q3 = 2'h3,
    IOD_Q4 = 2'h2
  } iod_phase_type;

  // ========================================================================
  // Instructions handled by this block
  typedef enum logic [1:0] {
    IOD_K_NONE = 2'h0,
    IOD_K_ADD  = 2'h1,
    IOD_K_BSET = 2'h2,
    IOD_K_FILL = 2'h3
  } iod_kind_type;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcy;
    logic cy;
  } iod_flags_type;

endpackage

// ===== tb/iod_core_bench.sv
// Self-checking bench of the indexed operand decoder core.
// Assumes iod_params.svh on the include path; the bench itself acts as data memory.
`timescale 1ns/10ps
`include "iod_params.svh"

module iod_core_bench;
  logic        ref_clk;
  logic        reset;
  logic [15:0] instr_word;
  logic        instr_valid;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [11:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_rdata = 8'h00;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic        phase_q1;
  logic        exec_done;
  logic [7:0]  mem [0:4095];
  int          n_errors;
  int          cmp_count;
  int          seed;
  logic        m_ext;
  logic [11:0] m_fp;
  logic [3:0]  m_bank;
  logic [7:0]  m_work;
  logic [4:0]  m_stat;

  iod_core i_iod_core (
    .REF_CLK     (ref_clk),
    .RESET       (reset),
    .INSTR_WORD  (instr_word),
    .INSTR_VALID (instr_valid),
    .REG_ADDR    (reg_addr),
    .REG_WDATA   (reg_wdata),
    .REG_WR      (reg_wr),
    .REG_RD      (reg_rd),
    .REG_RDATA   (reg_rdata),
    .MEM_ADDR    (mem_addr),
    .MEM_RD      (mem_rd),
    .MEM_RDATA   (mem_rdata),
    .MEM_WR      (mem_wr),
    .MEM_WDATA   (mem_wdata),
    .PHASE_Q1    (phase_q1),
    .EXEC_DONE   (exec_done)
  );

  // ==========================================================================
  // Clock and data memory
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // Read data only in the cycle after a read; otherwise a toggling pattern
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // ==========================================================================
  // Checking and closing
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register port
  task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic setup(input logic e, input logic [11:0] fp, input logic [3:0] bk,
                       input logic [7:0] wk);
    m_ext  = e;
    m_fp   = fp;
    m_bank = bk;
    m_work = wk;
    reg_wr_t(`IOD_REG_CFG, {7'h00, e});
    reg_wr_t(`IOD_REG_FP_LO, fp[7:0]);
    reg_wr_t(`IOD_REG_FP_HI, {4'h0, fp[11:8]});
    reg_wr_t(`IOD_REG_BANK, {4'h0, bk});
    reg_wr_t(`IOD_REG_WORK, wk);
  endtask

  // ==========================================================================
  // Instruction model
  function automatic iod_pkg::iod_kind_type kind_of(input logic [15:0] w);
    if (w[15:10] == `IOD_OP_ADD) return iod_pkg::IOD_K_ADD;
    if (w[15:12] == `IOD_OP_BSET) return iod_pkg::IOD_K_BSET;
    if (w[15:9] == `IOD_OP_FILL) return iod_pkg::IOD_K_FILL;
    return iod_pkg::IOD_K_NONE;
  endfunction

  function automatic logic [11:0] eff_of(input logic [15:0] w);
    if (w[8]) return {m_bank, w[7:0]};
    if (w[7:0] > `IOD_OFFSET_LIMIT) return {`IOD_HIGH_PAGE, w[7:0]};
    return m_ext ? m_fp + {4'h0, w[7:0]} : {`IOD_LOW_PAGE, w[7:0]};
  endfunction

  task automatic run_instr(input logic [15:0] w);
    iod_pkg::iod_kind_type k;
    logic [11:0] ea;
    logic [7:0]  b;
    logic [8:0]  s;
    logic        wr;
    logic [7:0]  wd;
    k  = kind_of(w);
    ea = eff_of(w);
    b  = mem[ea];
    s  = {1'b0, m_work} + {1'b0, b};
    wr = (k != iod_pkg::IOD_K_NONE) && !(k == iod_pkg::IOD_K_ADD && !w[9]);
    wd = (k == iod_pkg::IOD_K_ADD) ? s[7:0] :
         (k == iod_pkg::IOD_K_BSET) ? (b | (8'h01 << w[11:9])) : `IOD_FILL_VALUE;
    // Sync on Q1, then present the word in the following Q1
    do @(negedge ref_clk); while (phase_q1 !== 1'b1);
    repeat (4) @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
    @(negedge ref_clk);
    chk("mem_rd", {15'h0, mem_rd}, {15'h0, k == iod_pkg::IOD_K_ADD || k == iod_pkg::IOD_K_BSET});
    if (k != iod_pkg::IOD_K_NONE) begin
      chk("mem_addr", {4'h0, mem_addr}, {4'h0, ea});
    end
    repeat (2) @(negedge ref_clk);
    chk("exec_done", {15'h0, exec_done}, {15'h0, k != iod_pkg::IOD_K_NONE});
    chk("mem_wr", {15'h0, mem_wr}, {15'h0, wr});
    chk("phase_q1", {15'h0, phase_q1}, 16'h0000);
    if (wr) begin
      chk("mem_wdata", {8'h00, mem_wdata}, {8'h00, wd});
    end
    if (k == iod_pkg::IOD_K_ADD) begin
      m_stat = {s[7], (m_work[7] == b[7]) && (s[7] != m_work[7]), s[7:0] == 8'h00,
                ({1'b0, m_work[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
      if (!w[9]) begin
        m_work = s[7:0];
      end
    end
    reg_chk(`IOD_REG_WORK, m_work);
    reg_chk(`IOD_REG_STATUS, {3'h0, m_stat});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    seed        = 32'h466d;
    n_errors    = 0;
    cmp_count   = 0;
    m_stat      = 5'h00;
    reset       = 1'b1;
    instr_word  = 16'h0000;
    instr_valid = 1'b0;
    reg_addr    = 3'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    for (int a = 0; a < 4096; a++) mem[a] = $random(seed);
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // The cycle after release is still a Q1 cycle
    @(negedge ref_clk);
    chk("phase_q1", {15'h0, phase_q1}, 16'h0001);
    for (int a = 0; a < 8; a++) reg_chk(a[2:0], 8'h00);
    // Read-only status and an unmapped place keep their value
    reg_wr_t(`IOD_REG_STATUS, 8'h1F);
    reg_wr_t(3'h6, 8'hA5);
    reg_chk(`IOD_REG_STATUS, 8'h00);
    reg_chk(3'h6, 8'h00);
    setup(1'b1, 12'hA00, 4'h3, 8'h17);
    mem[12'hA2C] = 8'h20;
    mem[12'hA0A] = 8'h55;
    run_instr(16'h242C);
    run_instr(16'h8E0A);
    run_instr(16'h682C);
    run_instr(16'h265F);
    run_instr(16'h2660);
    run_instr(16'h2760);
    run_instr(16'h0000);
    setup(1'b1, 12'hFFF, 4'hC, 8'h01);
    run_instr(16'h685F);
    setup(1'b1, 12'h000, 4'h0, 8'h10);
    run_instr(16'h8010);
    setup(1'b0, 12'hA00, 4'h5, 8'h10);
    run_instr(16'h8210);
    run_instr(16'h6801);
    // Flag corners: signed overflow, then carry with zero result
    setup(1'b1, 12'h100, 4'h0, 8'h7F);
    mem[12'h100] = 8'h01;
    run_instr(16'h2400);
    setup(1'b1, 12'h100, 4'h0, 8'hFF);
    run_instr(16'h2400);
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      setup(r[0], r[27:16], r[31:28], r[15:8]);
      r = $random(seed);
      case (r[17:16])
        2'h0: w = {6'h09, r[9:8], r[7:0]};
        2'h1: w = {4'h8, r[11:8], r[7:0]};
        2'h2: w = {7'h34, r[8], r[7:0]};
        default: w = r[15:0];
      endcase
      run_instr(w);
    end
    complete_run();
  end

  // Roughly fourteen times the expected run length
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
endmodule // iod_core_bench
